// >>> dosel_load.sv
// far-side load model: equipment wired to both terminals, counts switch-on steps
`timescale 1ns/10ps
module dosel_load (
	// clock
	input  wire logic aclk,
	// terminals
	input  wire logic tr_in,
	input  wire logic rl_in,
	// activity
	output int        toggles
);
	logic [1:0] last_q = 2'b00;
	int         rises  = 0;
	// only a clean low-to-high step counts; the unknown level before reset is no switch-on
	always @(posedge aclk) begin
		rises <= rises + int'(tr_in === 1'b1 && last_q[0] === 1'b0)
			+ int'(rl_in === 1'b1 && last_q[1] === 1'b0);
		last_q <= {rl_in, tr_in};
	end
	assign toggles = rises;
endmodule

// >>> dosel_pkg.sv
// package: codes, register map, field layouts and carriers of the output condition selector
package dosel_pkg;

	localparam int FW = 16;

	// ****************************************
	// selection codes
	// ****************************************
	localparam logic [4:0] CODE_NONE     = 5'h00;
	localparam logic [4:0] CODE_RUN      = 5'h01;
	localparam logic [4:0] CODE_ARRIVE   = 5'h02;
	localparam logic [4:0] CODE_FDT_ONE  = 5'h03;
	localparam logic [4:0] CODE_FDT_TWO  = 5'h04;
	localparam logic [4:0] CODE_REVERSE  = 5'h05;
	localparam logic [4:0] CODE_JOG      = 5'h06;
	localparam logic [4:0] CODE_FAULT    = 5'h07;
	localparam logic [4:0] CODE_READY    = 5'h08;
	localparam logic [4:0] CODE_UPPER    = 5'h09;
	localparam logic [4:0] CODE_LOWER    = 5'h0A;
	localparam logic [4:0] CODE_ILIMIT   = 5'h0B;
	localparam logic [4:0] CODE_OVSTALL  = 5'h0C;
	localparam logic [4:0] CODE_SEQ_DONE = 5'h0D;
	localparam logic [4:0] CODE_COUNT    = 5'h0E;
	localparam logic [4:0] CODE_MIDCOUNT = 5'h0F;
	localparam logic [4:0] CODE_LENGTH   = 5'h10;
	localparam logic [4:0] CODE_OVERLOAD = 5'h11;
	localparam logic [4:0] CODE_OVERHEAT = 5'h12;
	localparam logic [4:0] CODE_PID_HIGH = 5'h13;
	localparam logic [4:0] CODE_PID_LOW  = 5'h14;

	// ****************************************
	// fixed hysteresis widths (value units: 0.1 %, 1 V, 1 degC)
	// ****************************************
	localparam logic [FW-1:0] ILIMIT_HYST    = 16'h0032;
	localparam logic [FW-1:0] OVSTALL_HYST   = 16'h000A;
	localparam logic [FW-1:0] HEAT_SET_DROP  = 16'h000A;
	localparam logic [FW-1:0] HEAT_CLR_DROP  = 16'h000F;

	// ****************************************
	// register map (byte addresses) and reset values
	// ****************************************
	localparam logic [7:0] A_SEL       = 8'h00;
	localparam logic [7:0] A_ARR_WIDTH = 8'h04;
	localparam logic [7:0] A_L1_THR    = 8'h08;
	localparam logic [7:0] A_L1_HYS    = 8'h0C;
	localparam logic [7:0] A_L2_THR    = 8'h10;
	localparam logic [7:0] A_L2_HYS    = 8'h14;
	localparam logic [7:0] A_UPPER_A   = 8'h18;
	localparam logic [7:0] A_UPPER_B   = 8'h1C;
	localparam logic [7:0] A_LOWER     = 8'h20;
	localparam logic [7:0] A_ILIMIT    = 8'h24;
	localparam logic [7:0] A_OVSTALL   = 8'h28;
	localparam logic [7:0] A_SEQ_CFG   = 8'h2C;
	localparam logic [7:0] A_CNT_SET   = 8'h30;
	localparam logic [7:0] A_CNT_MID   = 8'h34;
	localparam logic [7:0] A_LEN_SET   = 8'h38;
	localparam logic [7:0] A_OVL_COEF  = 8'h3C;
	localparam logic [7:0] A_PID_UP    = 8'h40;
	localparam logic [7:0] A_PID_LO    = 8'h44;
	localparam logic [7:0] A_STATUS    = 8'h48;
	localparam int         NREG        = 19;

	// sel register: transistor code [4:0], relay code [12:8]
	localparam int SEL_TR_LSB = 0;
	localparam int SEL_RL_LSB = 8;
	// seq cfg: pass count [15:0], stop mode bit 16 (0 single, 1 limited)
	localparam int SEQ_MODE_BIT = 16;

	localparam logic [4:0] RST_TR_CODE = 5'h01;
	localparam logic [4:0] RST_RL_CODE = 5'h07;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic          running;
		logic          jog_active;
		logic          reverse_run_flag;
		logic          fault;
		logic          ready;
		logic          seq_stopped;
		logic [FW-1:0] seq_passes_done;
		logic          seq_reset;
	} dosel_status_s;

	typedef struct packed {
		logic [FW-1:0] output_frequency_value;
		logic [FW-1:0] set_frequency_value;
		logic [FW-1:0] output_current_value;
		logic [FW-1:0] output_voltage_value;
		logic [FW-1:0] pulse_count_value;
		logic [FW-1:0] pulse_length_value;
		logic [FW-1:0] motor_load_value;
		logic [FW-1:0] heatsink_temp_value;
		logic [FW-1:0] hot_spot_level;
		logic [FW-1:0] pid_feedback_value;
	} dosel_meas_s;

	typedef struct packed {
		logic [4:0]    tr_code;
		logic [4:0]    rl_code;
		logic [FW-1:0] freq_arrival_width;
		logic [FW-1:0] freq_level_one_threshold;
		logic [FW-1:0] freq_level_one_hysteresis;
		logic [FW-1:0] freq_level_two_threshold;
		logic [FW-1:0] freq_level_two_hysteresis;
		logic [FW-1:0] upper_freq_limit_a;
		logic [FW-1:0] upper_freq_limit_b;
		logic [FW-1:0] lower_freq_limit;
		logic [FW-1:0] current_limit_level;
		logic [FW-1:0] overvoltage_stall_level;
		logic          sequencer_stop_mode;
		logic [FW-1:0] sequencer_pass_count;
		logic [FW-1:0] set_count_target;
		logic [FW-1:0] intermediate_count_target;
		logic [FW-1:0] set_length_target;
		logic [FW-1:0] overload_prealarm_coeff;
		logic [FW-1:0] pid_upper_limit;
		logic [FW-1:0] pid_lower_limit;
	} dosel_cfg_s;

	// hysteresis lower point, floored at zero
	function automatic logic [FW-1:0] sub_floor(input logic [FW-1:0] a, input logic [FW-1:0] b);
		return (a > b) ? a - b : '0;
	endfunction

endpackage

// >>> dosel_regs.sv
// AXI4-Lite register slave holding the selector configuration
`timescale 1ns/10ps
module dosel_regs import dosel_pkg::*; (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// write channels
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// read channels
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// block side
	input  wire logic [1:0]  term_state,
	output dosel_cfg_s       cfg
);

	typedef struct packed {
		logic [NREG-1:0][31:0] r;
		logic                  aw_got;
		logic [7:0]            aw_addr;
		logic                  w_got;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
	} dosel_regs_s;

	dosel_regs_s q, d;
	logic [4:0]  widx;
	logic [4:0]  ridx;

	always_comb begin
		d = q;
		widx = q.aw_addr[6:2];
		ridx = araddr[6:2];
		if (awvalid && !q.aw_got) begin
			d.aw_got = 1'b1;
			d.aw_addr = awaddr;
		end
		if (wvalid && !q.w_got) begin
			d.w_got = 1'b1;
			d.w_data = wdata;
			d.w_strb = wstrb;
		end
		if (q.aw_got && q.w_got && !q.bvalid) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			// status word is read-only; writes to it or past the map are refused
			if (q.aw_addr[1:0] == 2'b00 && q.aw_addr < A_STATUS) begin
				d.bresp = RESP_OKAY;
				for (int b = 0; b < 4; b++) begin
					if (q.w_strb[b]) begin
						d.r[widx][b*8 +: 8] = q.w_data[b*8 +: 8];
					end
				end
			end else begin
				d.bresp = RESP_SLVERR;
			end
		end
		if (q.bvalid && bready) begin
			d.bvalid = 1'b0;
		end
		if (arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			if (araddr == A_STATUS) begin
				d.rdata = {30'h0, term_state};
				d.rresp = RESP_OKAY;
			end else if (araddr[1:0] == 2'b00 && araddr < A_STATUS) begin
				d.rdata = q.r[ridx];
				d.rresp = RESP_OKAY;
			end else begin
				d.rdata = 32'h0000_0000;
				d.rresp = RESP_SLVERR;
			end
		end else if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.r[0] <= {19'h0, RST_RL_CODE, 3'h0, RST_TR_CODE};
		end else begin
			q <= d;
		end
	end

	assign awready = !q.aw_got;
	assign wready  = !q.w_got;
	assign bvalid  = q.bvalid;
	assign bresp   = q.bresp;
	assign arready = !q.rvalid;
	assign rvalid  = q.rvalid;
	assign rdata   = q.rdata;
	assign rresp   = q.rresp;

	assign cfg.tr_code                   = q.r[0][SEL_TR_LSB +: 5];
	assign cfg.rl_code                   = q.r[0][SEL_RL_LSB +: 5];
	assign cfg.freq_arrival_width        = q.r[1][FW-1:0];
	assign cfg.freq_level_one_threshold  = q.r[2][FW-1:0];
	assign cfg.freq_level_one_hysteresis = q.r[3][FW-1:0];
	assign cfg.freq_level_two_threshold  = q.r[4][FW-1:0];
	assign cfg.freq_level_two_hysteresis = q.r[5][FW-1:0];
	assign cfg.upper_freq_limit_a        = q.r[6][FW-1:0];
	assign cfg.upper_freq_limit_b        = q.r[7][FW-1:0];
	assign cfg.lower_freq_limit          = q.r[8][FW-1:0];
	assign cfg.current_limit_level       = q.r[9][FW-1:0];
	assign cfg.overvoltage_stall_level   = q.r[10][FW-1:0];
	assign cfg.sequencer_pass_count      = q.r[11][FW-1:0];
	assign cfg.sequencer_stop_mode       = q.r[11][SEQ_MODE_BIT];
	assign cfg.set_count_target          = q.r[12][FW-1:0];
	assign cfg.intermediate_count_target = q.r[13][FW-1:0];
	assign cfg.set_length_target         = q.r[14][FW-1:0];
	assign cfg.overload_prealarm_coeff   = q.r[15][FW-1:0];
	assign cfg.pid_upper_limit           = q.r[16][FW-1:0];
	assign cfg.pid_lower_limit           = q.r[17][FW-1:0];

endmodule

// >>> dosel_term.sv
// one output terminal: condition picked by its code, with hysteresis hold
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/10ps
module dosel_term import dosel_pkg::*; (
	// clock and reset
	input  wire logic     aclk,
	input  wire logic     aresetn,
	// selection and inputs
	input  wire logic [4:0]    code,
	input  wire dosel_cfg_s    cfg,
	input  wire dosel_status_s st,
	input  wire dosel_meas_s   ms,
	// terminal state
	output logic          term_q
);

	typedef struct packed {
		logic term;
		logic live;
	} dosel_term_s;

	dosel_term_s q, d;
	logic [FW-1:0] fdiff;
	logic [FW-1:0] upper;
	logic          jog_or_run;
	logic          seq_done;

	always_comb begin
		d = q;
		// low for the first edge after reset, when the terminal is still forced clear
		d.live = 1'b1;
		fdiff = (ms.output_frequency_value > ms.set_frequency_value)
			? ms.output_frequency_value - ms.set_frequency_value
			: ms.set_frequency_value - ms.output_frequency_value;
		upper = (cfg.upper_freq_limit_a < cfg.upper_freq_limit_b)
			? cfg.upper_freq_limit_a : cfg.upper_freq_limit_b;
		jog_or_run = st.running || st.jog_active;
		seq_done = st.seq_stopped && !st.running && !st.seq_reset &&
			(cfg.sequencer_stop_mode ? (st.seq_passes_done >= cfg.sequencer_pass_count)
				: (st.seq_passes_done >= 16'h0001));
		// each terminal acts on its own code
		case (code)
			CODE_NONE: d.term = 1'b0;
			CODE_RUN: d.term = jog_or_run;
			CODE_ARRIVE: d.term = st.running && (fdiff <= cfg.freq_arrival_width);
			CODE_FDT_ONE: begin
				if (!st.running || ms.output_frequency_value <= sub_floor(
					cfg.freq_level_one_threshold, cfg.freq_level_one_hysteresis)) begin
					d.term = 1'b0;
				end else if (ms.output_frequency_value > cfg.freq_level_one_threshold) begin
					d.term = 1'b1;
				end
			end
			CODE_FDT_TWO: begin
				if (!st.running || ms.output_frequency_value <= sub_floor(
					cfg.freq_level_two_threshold, cfg.freq_level_two_hysteresis)) begin
					d.term = 1'b0;
				end else if (ms.output_frequency_value > cfg.freq_level_two_threshold) begin
					d.term = 1'b1;
				end
			end
			CODE_REVERSE: d.term = st.running && st.reverse_run_flag;
			CODE_JOG: d.term = st.jog_active;
			CODE_FAULT: d.term = st.fault;
			CODE_READY: d.term = st.ready && !st.fault;
			CODE_UPPER: d.term = jog_or_run && ms.output_frequency_value >= upper &&
				ms.set_frequency_value >= upper;
			CODE_LOWER: d.term = jog_or_run &&
				ms.output_frequency_value <= cfg.lower_freq_limit &&
				ms.set_frequency_value <= cfg.lower_freq_limit;
			CODE_ILIMIT: begin
				if (ms.output_current_value >= cfg.current_limit_level) begin
					d.term = 1'b1;
				end else if (ms.output_current_value <=
					sub_floor(cfg.current_limit_level, ILIMIT_HYST)) begin
					d.term = 1'b0;
				end
			end
			CODE_OVSTALL: begin
				if (ms.output_voltage_value >= cfg.overvoltage_stall_level) begin
					d.term = 1'b1;
				end else if (ms.output_voltage_value <=
					sub_floor(cfg.overvoltage_stall_level, OVSTALL_HYST)) begin
					d.term = 1'b0;
				end
			end
			CODE_SEQ_DONE: d.term = seq_done;
			CODE_COUNT: d.term = ms.pulse_count_value >= cfg.set_count_target;
			CODE_MIDCOUNT: d.term = ms.pulse_count_value >= cfg.intermediate_count_target;
			CODE_LENGTH: d.term = ms.pulse_length_value >= cfg.set_length_target;
			CODE_OVERLOAD: d.term = ms.motor_load_value >= cfg.overload_prealarm_coeff;
			CODE_OVERHEAT: begin
				if (ms.heatsink_temp_value >= sub_floor(ms.hot_spot_level, HEAT_SET_DROP)) begin
					d.term = 1'b1;
				end else if (ms.heatsink_temp_value <
					sub_floor(ms.hot_spot_level, HEAT_CLR_DROP)) begin
					d.term = 1'b0;
				end
			end
			CODE_PID_HIGH: d.term = st.running && ms.pid_feedback_value >= cfg.pid_upper_limit;
			CODE_PID_LOW: d.term = st.running && ms.pid_feedback_value <= cfg.pid_lower_limit;
			default: d.term = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign term_q = q.term;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn || !q.live);

	a_fault_follows: assert property ((code == CODE_FAULT) |=> term_q == $past(st.fault))
		else $error("fault terminal mismatch");
	a_jog_follows: assert property ((code == CODE_JOG) |=> term_q == $past(st.jog_active))
		else $error("jog terminal mismatch");
	a_arrive_off: assert property ((code == CODE_ARRIVE && !st.running) |=> !term_q)
		else $error("arrival set while stopped");
	a_fdt_one_hold: assert property (
		(code == CODE_FDT_ONE && $stable(code) && st.running &&
		ms.output_frequency_value <= cfg.freq_level_one_threshold &&
		ms.output_frequency_value > sub_floor(cfg.freq_level_one_threshold,
		cfg.freq_level_one_hysteresis)) |=> term_q == $past(term_q))
		else $error("level one not held");
	a_fdt_one_set: assert property ((code == CODE_FDT_ONE && st.running &&
		ms.output_frequency_value > cfg.freq_level_one_threshold) |=> term_q)
		else $error("level one not set");
	a_fdt_two_clr: assert property ((code == CODE_FDT_TWO && !st.running) |=> !term_q)
		else $error("level two not cleared");
	a_ilimit_set: assert property ((code == CODE_ILIMIT &&
		ms.output_current_value >= cfg.current_limit_level) |=> term_q)
		else $error("current limit not set");
	a_count_tracks: assert property ((code == CODE_COUNT) |=>
		term_q == ($past(ms.pulse_count_value) >= $past(cfg.set_count_target)))
		else $error("count terminal mismatch");
	a_reverse_off: assert property ((code == CODE_REVERSE && !st.reverse_run_flag)
		|=> !term_q)
		else $error("reverse set when forward");

	c_fdt_one_rise: cover property (code == CODE_FDT_ONE ##1 $rose(term_q));
	c_ilimit_hold: cover property (code == CODE_ILIMIT && term_q ##1 term_q [*3] ##1 !term_q);
	c_overheat: cover property (code == CODE_OVERHEAT ##1 $rose(term_q));

endmodule

// >>> dosel_top.sv
// top: register slave plus the two terminal selectors
`timescale 1ns/10ps
module dosel_top import dosel_pkg::*; (
	// clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// axi4-lite write
	input  wire logic [7:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	// drive status and measurements
	input  wire dosel_status_s drive_status,
	input  wire dosel_meas_s   drive_meas,
	// terminals
	output logic               transistor_output_terminal,
	output logic               relay_output_terminal
);

	dosel_cfg_s cfg;
	logic       tr_q;
	logic       rl_q;

	dosel_regs u_regs (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.awaddr     (s_axi_awaddr),
		.awvalid    (s_axi_awvalid),
		.awready    (s_axi_awready),
		.wdata      (s_axi_wdata),
		.wstrb      (s_axi_wstrb),
		.wvalid     (s_axi_wvalid),
		.wready     (s_axi_wready),
		.bresp      (s_axi_bresp),
		.bvalid     (s_axi_bvalid),
		.bready     (s_axi_bready),
		.araddr     (s_axi_araddr),
		.arvalid    (s_axi_arvalid),
		.arready    (s_axi_arready),
		.rdata      (s_axi_rdata),
		.rresp      (s_axi_rresp),
		.rvalid     (s_axi_rvalid),
		.rready     (s_axi_rready),
		.term_state ({rl_q, tr_q}),
		.cfg        (cfg)
	);

	dosel_term u_tr (
		.aclk    (aclk),
		.aresetn (aresetn),
		.code    (cfg.tr_code),
		.cfg     (cfg),
		.st      (drive_status),
		.ms      (drive_meas),
		.term_q  (tr_q)
	);

	dosel_term u_rl (
		.aclk    (aclk),
		.aresetn (aresetn),
		.code    (cfg.rl_code),
		.cfg     (cfg),
		.st      (drive_status),
		.ms      (drive_meas),
		.term_q  (rl_q)
	);

	assign transistor_output_terminal = tr_q;
	assign relay_output_terminal      = rl_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// the terminal flop is still forced clear at the release edge, so skip that start
	a_fault_relay: assert property (($past(aresetn) && cfg.rl_code == CODE_FAULT &&
		drive_status.fault) |=> relay_output_terminal)
		else $error("relay not set in fault");
	c_both_on: cover property (transistor_output_terminal && relay_output_terminal);

endmodule

// >>> tb.sv
// testbench: random drive state against a behavioural selector model
`timescale 1ns/10ps
module tb import dosel_pkg::*;;
	logic          aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic          arvalid = 0, rready = 0, rnd_on = 0, cmp_on = 0;
	logic          awready, wready, bvalid, arready, rvalid, tr_o, rl_o;
	logic [7:0]    awaddr = 0, araddr = 0;
	logic [31:0]   wdata = 0, rdata, d;
	logic [3:0]    wstrb = 0;
	logic [1:0]    bresp, rresp, rsp;
	dosel_status_s st = '0;
	dosel_meas_s   ms = '0, mr;
	bit            et, er;
	int            err_total = 0, checks = 0, tc, rc, toggles;
	// config table, word index from 0x04; slot 10 is the sequencer word
	int v[17] = '{5, 50, 10, 30, 5, 90, 80, 10, 100, 100, 0, 40, 20, 60, 70, 80, 20};

	initial forever #10 aclk = ~aclk;

	dosel_top u_dosel_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .drive_status(st),
		.drive_meas(ms), .transistor_output_terminal(tr_o), .relay_output_terminal(rl_o));
	dosel_load u_dosel_load (.aclk(aclk), .tr_in(tr_o), .rl_in(rl_o), .toggles(toggles));

	task automatic finish_test();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic tmo(int n);
		if (n >= 100) begin
			err_total++;
			finish_test();
		end
	endtask
	// ****************************************
	// axi4-lite master
	// ****************************************
	task automatic axw(logic [7:0] a, logic [31:0] dd, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= dd;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
		end while (bvalid !== 1'b1 && n < 100);
		tmo(n);
		r = bresp;
		bready <= 0;
	endtask
	task automatic axr(logic [7:0] a, output logic [31:0] dd, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 0;
		end while (rvalid !== 1'b1 && n < 100);
		tmo(n);
		dd = rdata;
		r = rresp;
		rready <= 0;
	endtask
	// ****************************************
	// reference model
	// ****************************************
	function automatic bit hy(bit s, bit c, bit p);
		return s ? 1'b1 : (c ? 1'b0 : p);
	endfunction
	function automatic int sb(int a, int b);
		return a > b ? a - b : 0;
	endfunction
	function automatic bit mdl(int c, bit p);
		int fo, fs, u, cu, vo, tp, ht;
		bit go;
		fo = ms.output_frequency_value;
		fs = ms.set_frequency_value;
		cu = ms.output_current_value;
		vo = ms.output_voltage_value;
		tp = ms.heatsink_temp_value;
		ht = ms.hot_spot_level;
		u = v[5] < v[6] ? v[5] : v[6];
		go = st.running || st.jog_active;
		case (c)
		1: return go;
		2: return st.running && (fo > fs ? fo - fs : fs - fo) <= v[0];
		3: return hy(st.running && fo > v[1], !st.running || fo <= sb(v[1], v[2]), p);
		4: return hy(st.running && fo > v[3], !st.running || fo <= sb(v[3], v[4]), p);
		5: return st.running && st.reverse_run_flag;
		6: return st.jog_active;
		7: return st.fault;
		8: return st.ready && !st.fault;
		9: return go && fo >= u && fs >= u;
		10: return go && fo <= v[7] && fs <= v[7];
		11: return hy(cu >= v[8], cu <= sb(v[8], ILIMIT_HYST), p);
		12: return hy(vo >= v[9], vo <= sb(v[9], OVSTALL_HYST), p);
		13: return st.seq_stopped && !st.running && !st.seq_reset
			&& st.seq_passes_done >= (v[10] > 65535 ? v[10] % 65536 : 1);
		14: return ms.pulse_count_value >= v[11];
		15: return ms.pulse_count_value >= v[12];
		16: return ms.pulse_length_value >= v[13];
		17: return ms.motor_load_value >= v[14];
		18: return hy(tp >= sb(ht, HEAT_SET_DROP), tp < sb(ht, HEAT_CLR_DROP), p);
		19: return st.running && ms.pid_feedback_value >= v[15];
		20: return st.running && ms.pid_feedback_value <= v[16];
		default: return 0;
		endcase
	endfunction

	always @(posedge aclk) begin
		if (rnd_on) begin
			st <= {5'($urandom), 1'($urandom), 16'($urandom_range(7)), 1'($urandom_range(3) == 0)};
			for (int i = 0; i < 10; i++) mr[i*16 +: 16] = 16'($urandom_range(127));
			mr.hot_spot_level = 16'($urandom_range(127, 20));
			ms <= mr;
		end
	end
	// model steps with the design; it restarts from the quiet state after each code change
	always @(posedge aclk) begin
		if (!cmp_on) begin
			et = 0;
			er = 0;
		end else begin
			chk("transistor", 32'(tr_o), 32'(et));
			chk("relay", 32'(rl_o), 32'(er));
			et = mdl(tc, et);
			er = mdl(rc, er);
		end
	end

	initial begin
		void'($urandom(16));
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		axr(A_SEL, d, rsp);
		chk("sel reset", d, 32'h0000_0701);
		chk("sel reset resp", 32'(rsp), 32'(RESP_OKAY));
		axr(8'h4C, d, rsp);
		chk("unmapped data", d, 32'h0000_0000);
		chk("unmapped resp", 32'(rsp), 32'(RESP_SLVERR));
		axw(A_STATUS, 32'h0000_0003, rsp);
		chk("status write resp", 32'(rsp), 32'(RESP_SLVERR));
		for (int p = 0; p < 2; p++) begin
			v[10] = p ? 32'h0001_0003 : 32'h0000_0003;
			for (int i = 0; i < 17; i++) begin
				axw(8'(4 * i + 4), 32'(v[i]), rsp);
				chk("cfg write resp", 32'(rsp), 32'(RESP_OKAY));
				axr(8'(4 * i + 4), d, rsp);
				chk("cfg readback", d, 32'(v[i]));
				chk("cfg read resp", 32'(rsp), 32'(RESP_OKAY));
			end
			// codes above 20 included on purpose: they must stay off
			for (int c = 0; c < 23; c++) begin
				cmp_on <= 0;
				@(posedge aclk);
				tc = c;
				rc = 22 - c;
				axw(A_SEL, (32'(rc) << 8) | 32'(tc), rsp);
				st <= '0;
				ms <= '{hot_spot_level: 16'h0040, default: '0};
				repeat (2) @(posedge aclk);
				cmp_on <= 1;
				rnd_on <= 1;
				repeat (60) @(posedge aclk);
				rnd_on <= 0;
				repeat (3) @(posedge aclk);
				axr(A_STATUS, d, rsp);
				chk("status", d, {30'h0, er, et});
				chk("status resp", 32'(rsp), 32'(RESP_OKAY));
			end
		end
		// mid-run reset with both terminals on: they drop, codes return to their reset values
		cmp_on <= 0;
		axw(A_SEL, 32'h0000_0707, rsp);
		st <= '{fault: 1'b1, default: '0};
		repeat (2) @(posedge aclk);
		chk("fault both", 32'({rl_o, tr_o}), 32'h0000_0003);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		chk("reset terminals", 32'({rl_o, tr_o}), 32'h0000_0000);
		aresetn <= 1;
		axr(A_SEL, d, rsp);
		chk("sel after reset", d, 32'h0000_0701);
		chk("relay after reset", 32'(rl_o), 32'h0000_0001);
		chk("load activity", 32'(toggles != 0), 32'h0000_0001);
		finish_test();
	end
endmodule
